//--- core/status_framer.sv
// Periodic vehicle status framer: APB register file, millisecond time base,
// per-group schedulers and a frame output towards the CAN controller.
// Assumes the CAN controller holds tx_ready low while it cannot take a frame.
//
// Summary of operation
// - Cruise/speed group every 100 ms, PS 241
// - Source address zero in every group
// - Cruise byte 1 bits all ones
// - Wheel speed in cruise bytes 2 and 3
// - Byte 4 holds pedal and cruise switch pairs
// - Byte 5 holds cruise command switch pairs
// - Cruise set speed in byte 6
// - Byte 7: cruise state and power takeoff
// - Byte 8 idle switches not supported, ones
// - Fuel group every 100 ms, PS 242
// - Inlet group every 500 ms, PS 246
// - Unsupported inlet bytes filled with ones
`timescale 1ns/100ps
module status_framer
    import status_framer_pkg::*;
#(
    parameter int unsigned ms_cycles = MS_CYCLES
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output frame_t           tx_frame,
    output logic             tx_valid,
    input  wire logic        tx_ready
);

    typedef enum logic {ST_IDLE, ST_SEND} tx_state_t;

    localparam logic [PERIOD_W-1:0] GROUP_PERIOD [NUM_GROUPS] =
        '{FAST_PERIOD_MS, FAST_PERIOD_MS, SLOW_PERIOD_MS};

    logic                  enable_r;
    measured_t             meas_r;
    logic [31:0]           prdata_r;
    logic                  pready_r;
    logic                  pslverr_r;
    logic [MS_CNT_W-1:0]   ms_cnt_r;
    logic                  ms_tick_r;
    logic [PERIOD_W-1:0]   grp_cnt_r [NUM_GROUPS];
    logic [NUM_GROUPS-1:0] due;
    logic [NUM_GROUPS-1:0] pending_r;
    logic [NUM_GROUPS-1:0] grant;
    group_t                grant_grp;
    frame_t                packed_frame;
    frame_t                tx_frame_r;
    logic                  tx_valid_r;
    tx_state_t             state_r;
    logic [7:0]            sent_cnt_r;
    logic                  setup;
    logic                  wr_en;
    logic                  mapped;
    logic [31:0]           rd_val;

    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign tx_frame = tx_frame_r;
    assign tx_valid = tx_valid_r;

    // The slave answers in the first access cycle: read data and the error
    // flag are registered during setup so the outputs come from flops.
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_r & pwrite & ~pslverr_r;

    always_comb
    begin
        rd_val = '0;
        mapped = 1'b1;
        unique case (paddr)
            ADDR_CTRL:   rd_val[CTRL_EN_BIT] = enable_r;
            ADDR_SPEED:
            begin
                rd_val[SPEED_LSB +: 16] = meas_r.speed;
                rd_val[SETSPD_LSB +: 8] = meas_r.set_speed;
            end
            ADDR_SWITCH:
            begin
                rd_val[PEDAL_LSB +: 8]   = {meas_r.clutch_sw, meas_r.brake_sw,
                                            meas_r.cc_enable_sw,
                                            meas_r.cc_active};
                rd_val[CMD_LSB +: 8]     = {meas_r.accel_sw, meas_r.resume_sw,
                                            meas_r.coast_sw, meas_r.set_sw};
                rd_val[CCSTATE_LSB +: 3] = meas_r.cruise_state;
                rd_val[PTO_LSB +: 5]     = meas_r.power_takeoff;
            end
            ADDR_FUEL:
            begin
                rd_val[RATE_LSB +: 16] = meas_r.fuel_rate;
                rd_val[ECON_LSB +: 16] = meas_r.avg_economy;
            end
            ADDR_INLET:
            begin
                rd_val[BOOST_LSB +: 8]  = meas_r.boost;
                rd_val[INTAKE_LSB +: 8] = meas_r.intake_temp;
            end
            ADDR_STATUS:
            begin
                rd_val[STAT_PEND_LSB +: NUM_GROUPS] = pending_r;
                rd_val[STAT_BUSY_BIT]               = tx_valid_r;
                rd_val[STAT_CNT_LSB +: 8]           = sent_cnt_r;
            end
            default:     mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end
        else
        begin
            pready_r  <= setup;
            pslverr_r <= setup & ~mapped;
            prdata_r  <= (setup & ~pwrite) ? rd_val : '0;
        end
    end

    // Register writes; the status register is read-only.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_r <= 1'b0;
            meas_r   <= '0;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                ADDR_CTRL:   enable_r <= pwdata[CTRL_EN_BIT];
                ADDR_SPEED:
                begin
                    meas_r.speed     <= pwdata[SPEED_LSB +: 16];
                    meas_r.set_speed <= pwdata[SETSPD_LSB +: 8];
                end
                ADDR_SWITCH:
                begin
                    {meas_r.clutch_sw, meas_r.brake_sw, meas_r.cc_enable_sw,
                     meas_r.cc_active} <= pwdata[PEDAL_LSB +: 8];
                    {meas_r.accel_sw, meas_r.resume_sw, meas_r.coast_sw,
                     meas_r.set_sw} <= pwdata[CMD_LSB +: 8];
                    meas_r.cruise_state  <= pwdata[CCSTATE_LSB +: 3];
                    meas_r.power_takeoff <= pwdata[PTO_LSB +: 5];
                end
                ADDR_FUEL:
                begin
                    meas_r.fuel_rate   <= pwdata[RATE_LSB +: 16];
                    meas_r.avg_economy <= pwdata[ECON_LSB +: 16];
                end
                ADDR_INLET:
                begin
                    meas_r.boost       <= pwdata[BOOST_LSB +: 8];
                    meas_r.intake_temp <= pwdata[INTAKE_LSB +: 8];
                end
                default:     enable_r <= enable_r;
            endcase
        end
    end

    // Millisecond time base, held in reset while transmission is disabled.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ms_cnt_r  <= '0;
            ms_tick_r <= 1'b0;
        end
        else if (!enable_r)
        begin
            ms_cnt_r  <= '0;
            ms_tick_r <= 1'b0;
        end
        else if (ms_cnt_r == MS_CNT_W'(ms_cycles - 1))
        begin
            ms_cnt_r  <= '0;
            ms_tick_r <= 1'b1;
        end
        else
        begin
            ms_cnt_r  <= ms_cnt_r + 1'b1;
            ms_tick_r <= 1'b0;
        end
    end

    // One period counter per group; a new due request wins over the grant
    // that clears the same pending bit.
    for (genvar g = 0; g < NUM_GROUPS; g++)
    begin : g_sched
        assign due[g] = ms_tick_r &
                        (grp_cnt_r[g] == GROUP_PERIOD[g] - 1'b1);

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                grp_cnt_r[g] <= '0;
                pending_r[g] <= 1'b0;
            end
            else if (!enable_r)
            begin
                grp_cnt_r[g] <= '0;
                pending_r[g] <= 1'b0;
            end
            else
            begin
                if (ms_tick_r)
                    grp_cnt_r[g] <= due[g] ? '0 : grp_cnt_r[g] + 1'b1;
                pending_r[g] <= due[g] | (pending_r[g] & ~grant[g]);
            end
        end
    end

    // Lowest-numbered pending group goes first.
    always_comb
    begin
        grant     = '0;
        grant_grp = GRP_CRUISE;
        if (state_r == ST_IDLE)
        begin
            if (pending_r[GRP_CRUISE])
                grant[GRP_CRUISE] = 1'b1;
            else if (pending_r[GRP_FUEL])
                grant[GRP_FUEL] = 1'b1;
            else if (pending_r[GRP_INLET])
                grant[GRP_INLET] = 1'b1;
        end
        if (grant[GRP_FUEL])
            grant_grp = GRP_FUEL;
        else if (grant[GRP_INLET])
            grant_grp = GRP_INLET;
    end

    frame_pack u_pack (
        .group (grant_grp),
        .meas  (meas_r),
        .frame (packed_frame)
    );

    // The frame is captured at grant, so it stays stable while offered.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r    <= ST_IDLE;
            tx_valid_r <= 1'b0;
            tx_frame_r <= '0;
            sent_cnt_r <= '0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                    if (|grant)
                    begin
                        tx_frame_r <= packed_frame;
                        tx_valid_r <= 1'b1;
                        state_r    <= ST_SEND;
                    end
                ST_SEND:
                    if (tx_ready)
                    begin
                        tx_valid_r <= 1'b0;
                        sent_cnt_r <= sent_cnt_r + 1'b1;
                        state_r    <= ST_IDLE;
                    end
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    src_addr_zero_a: assert property (
        tx_valid_r |-> tx_frame_r.id[ID_SA_LSB +: 8] == SRC_ADDR)
        else $error("source address not zero");
    id_fields_a: assert property (
        tx_valid_r |-> tx_frame_r.id[ID_PRIO_LSB +: 3] == PRIORITY_DEF &&
        tx_frame_r.id[ID_DP_LSB] == DATA_PAGE &&
        tx_frame_r.id[ID_PF_LSB +: 8] == PDU_FORMAT)
        else $error("identifier fields wrong");
    cruise_fill_a: assert property (
        tx_valid_r && tx_frame_r.id[ID_PS_LSB +: 8] == PS_CRUISE |->
        tx_frame_r.data[7:0] == NA_BYTE && tx_frame_r.data[63:56] == NA_BYTE)
        else $error("cruise fill bytes wrong");
    cruise_speed_a: assert property (
        $rose(tx_valid_r) && tx_frame_r.id[ID_PS_LSB +: 8] == PS_CRUISE |->
        tx_frame_r.data[23:8] == $past(meas_r.speed))
        else $error("vehicle speed misplaced");
    fuel_fill_a: assert property (
        tx_valid_r && tx_frame_r.id[ID_PS_LSB +: 8] == PS_FUEL |->
        tx_frame_r.data[31:16] == {2{NA_BYTE}} &&
        tx_frame_r.data[63:48] == {2{NA_BYTE}})
        else $error("fuel fill bytes wrong");
    inlet_fill_a: assert property (
        tx_valid_r && tx_frame_r.id[ID_PS_LSB +: 8] == PS_INLET |->
        tx_frame_r.data[7:0] == NA_BYTE &&
        tx_frame_r.data[63:24] == {5{NA_BYTE}})
        else $error("inlet fill bytes wrong");
    cruise_period_a: assert property (
        $rose(pending_r[GRP_CRUISE]) |->
        $past(grp_cnt_r[GRP_CRUISE]) == FAST_PERIOD_MS - 1'b1)
        else $error("cruise group off period");
    inlet_period_a: assert property (
        $rose(pending_r[GRP_INLET]) |->
        $past(grp_cnt_r[GRP_INLET]) == SLOW_PERIOD_MS - 1'b1)
        else $error("inlet group off period");
    frame_hold_a: assert property (
        tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_frame_r))
        else $error("frame changed while offered");
    apb_answer_a: assert property (
        psel && !penable |=> pready_r ##1 !pready_r)
        else $error("apb answer not one cycle");

    cruise_sent_c: cover property (tx_valid_r && tx_ready &&
        tx_frame_r.id[ID_PS_LSB +: 8] == PS_CRUISE);
    inlet_sent_c: cover property (tx_valid_r && tx_ready &&
        tx_frame_r.id[ID_PS_LSB +: 8] == PS_INLET);
    stall_c: cover property ((tx_valid_r && !tx_ready) [*3] ##1 tx_ready);

endmodule : status_framer

//--- common/status_framer_pkg.sv
// Constants, types and register map for the periodic vehicle status framer.
// Assumes a 100 MHz APB clock and a downstream CAN controller that takes
// one complete frame per valid/ready handshake.
package status_framer_pkg;

    // Time base.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_CNT_W      = 17;
    localparam int unsigned PERIOD_W      = 9;
    localparam int unsigned NUM_GROUPS    = 3;

    // Repetition periods in milliseconds: fast for cruise and fuel, slow for inlet.
    localparam logic [PERIOD_W-1:0] FAST_PERIOD_MS = 9'h064;
    localparam logic [PERIOD_W-1:0] SLOW_PERIOD_MS = 9'h1F4;

    // Identifier fields.
    localparam logic [2:0] PRIORITY_DEF  = 3'h6;
    localparam logic       RESERVED_BIT  = 1'h0;
    localparam logic       DATA_PAGE     = 1'h0;
    localparam logic [7:0] PDU_FORMAT    = 8'hFE;
    localparam logic [7:0] PS_CRUISE     = 8'hF1;
    localparam logic [7:0] PS_FUEL       = 8'hF2;
    localparam logic [7:0] PS_INLET      = 8'hF6;
    localparam logic [7:0] SRC_ADDR      = 8'h00;
    localparam logic [3:0] FRAME_DLC     = 4'h8;

    // Identifier field positions.
    localparam int unsigned ID_PRIO_LSB = 26;
    localparam int unsigned ID_DP_LSB   = 24;
    localparam int unsigned ID_PF_LSB   = 16;
    localparam int unsigned ID_PS_LSB   = 8;
    localparam int unsigned ID_SA_LSB   = 0;

    // Not-available fill values.
    localparam logic [7:0] NA_BYTE     = 8'hFF;
    localparam logic [1:0] NA_PAIR     = 2'h3;
    localparam logic [3:0] UNDEF_NIB   = 4'hF;

    // APB register offsets.
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_SPEED  = 8'h04;
    localparam logic [7:0] ADDR_SWITCH = 8'h08;
    localparam logic [7:0] ADDR_FUEL   = 8'h0C;
    localparam logic [7:0] ADDR_INLET  = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // Register field positions.
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned SPEED_LSB     = 0;
    localparam int unsigned SETSPD_LSB    = 16;
    localparam int unsigned PEDAL_LSB     = 0;
    localparam int unsigned CMD_LSB       = 8;
    localparam int unsigned CCSTATE_LSB   = 16;
    localparam int unsigned PTO_LSB       = 19;
    localparam int unsigned RATE_LSB      = 0;
    localparam int unsigned ECON_LSB      = 16;
    localparam int unsigned BOOST_LSB     = 0;
    localparam int unsigned INTAKE_LSB    = 8;
    localparam int unsigned STAT_PEND_LSB = 0;
    localparam int unsigned STAT_BUSY_BIT = 3;
    localparam int unsigned STAT_CNT_LSB  = 8;

    typedef enum logic [1:0] {GRP_CRUISE, GRP_FUEL, GRP_INLET} group_t;

    typedef struct packed {
        logic [28:0] id;
        logic [3:0]  dlc;
        logic [63:0] data;
    } frame_t;

    typedef struct packed {
        logic [15:0] speed;
        logic [7:0]  set_speed;
        logic [1:0]  clutch_sw;
        logic [1:0]  brake_sw;
        logic [1:0]  cc_enable_sw;
        logic [1:0]  cc_active;
        logic [1:0]  accel_sw;
        logic [1:0]  resume_sw;
        logic [1:0]  coast_sw;
        logic [1:0]  set_sw;
        logic [2:0]  cruise_state;
        logic [4:0]  power_takeoff;
        logic [15:0] fuel_rate;
        logic [15:0] avg_economy;
        logic [7:0]  boost;
        logic [7:0]  intake_temp;
    } measured_t;

    function automatic logic [28:0] make_id(input logic [7:0] ps);
        make_id = {PRIORITY_DEF, RESERVED_BIT, DATA_PAGE, PDU_FORMAT, ps,
                   SRC_ADDR};
    endfunction : make_id

endpackage : status_framer_pkg

//--- core/frame_pack.sv
// Packs the measured values of one parameter group into a CAN frame.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module frame_pack
    import status_framer_pkg::*;
(
    input  wire group_t    group,
    input  wire measured_t meas,
    output frame_t         frame
);

    logic [7:0] cruise_byte1;
    logic [7:0] pedal_byte;
    logic [7:0] command_byte;
    logic [7:0] state_byte;

    assign cruise_byte1 = {UNDEF_NIB, NA_PAIR, NA_PAIR};
    assign pedal_byte   = {meas.clutch_sw, meas.brake_sw,
                           meas.cc_enable_sw, meas.cc_active};
    assign command_byte = {meas.accel_sw, meas.resume_sw,
                           meas.coast_sw, meas.set_sw};
    assign state_byte   = {meas.cruise_state, meas.power_takeoff};

    // Byte n of the group sits at data[8n-1 -: 8]; multi-byte values are
    // sent low byte first.
    always_comb
    begin
        frame     = '0;
        frame.dlc = FRAME_DLC;
        unique case (group)
            GRP_CRUISE:
            begin
                frame.id   = make_id(PS_CRUISE);
                frame.data = {NA_BYTE, state_byte, meas.set_speed,
                              command_byte, pedal_byte,
                              meas.speed[15:8], meas.speed[7:0],
                              cruise_byte1};
            end
            GRP_FUEL:
            begin
                frame.id   = make_id(PS_FUEL);
                frame.data = {NA_BYTE, NA_BYTE,
                              meas.avg_economy[15:8], meas.avg_economy[7:0],
                              NA_BYTE, NA_BYTE,
                              meas.fuel_rate[15:8], meas.fuel_rate[7:0]};
            end
            GRP_INLET:
            begin
                frame.id   = make_id(PS_INLET);
                frame.data = {NA_BYTE, NA_BYTE, NA_BYTE, NA_BYTE,
                              NA_BYTE, meas.intake_temp, meas.boost,
                              NA_BYTE};
            end
            default:
            begin
                frame.id   = make_id(PS_CRUISE);
                frame.data = {8{NA_BYTE}};
            end
        endcase
    end

endmodule : frame_pack

//--- tb/can_sink.sv
// Behavioural CAN controller that takes frames from the framer.
// Assumes one frame per valid/ready handshake; stall holds ready low.
`timescale 1ns/100ps
module can_sink
    import status_framer_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   tx_valid,
    input  wire frame_t tx_frame,
    input  wire logic   stall,
    output logic        tx_ready,
    output logic        got,
    output frame_t      got_frame
);
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            tx_ready <= 1'b0;
        else
            tx_ready <= !stall;

    // Reports each accepted frame one cycle after the accepting edge.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            got       <= 1'b0;
            got_frame <= '0;
        end
        else
        begin
            got       <= tx_valid && tx_ready;
            got_frame <= tx_frame;
        end
endmodule : can_sink

//--- tb/tb_status_framer.sv
// Testbench for the status framer: APB set-up, frame content and timing.
// Assumes ms_cycles of 10, so 100 ms is 1000 clocks.
`timescale 1ns/100ps
`define CHK(nm, e, g) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("unexpected %s exp %h got %h", nm, e, g); \
        end \
    end
module tb_status_framer
    import status_framer_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    frame_t      tx_frame;
    frame_t      got_frame;
    frame_t      ef;
    logic        tx_valid;
    logic        tx_ready;
    logic        got;
    logic        stall;
    logic [31:0] q;
    logic        e;
    logic [31:0] sp_s;
    logic [31:0] sw_s;
    logic [31:0] fu_s;
    logic [31:0] in_s;
    group_t      g;
    group_t      exp_seq [0:12];
    int          t [0:12];
    int          cyc;
    int          nacc;
    int          err_total;
    int          cmp_count;

    status_framer #(.ms_cycles(10)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_frame(tx_frame),
        .tx_valid(tx_valid), .tx_ready(tx_ready)
    );

    can_sink sink (
        .pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
        .tx_frame(tx_frame), .stall(stall), .tx_ready(tx_ready),
        .got(got), .got_frame(got_frame)
    );

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // One APB transfer, entered just after a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    function automatic frame_t exp_frame(input group_t grp);
        logic [7:0]  ps;
        logic [63:0] d;
        case (grp)
            GRP_CRUISE:
            begin
                ps = 8'hF1;
                d = {8'hFF, sw_s[18:16], sw_s[23:19], sp_s[23:16],
                     sw_s[15:8], sw_s[7:0], sp_s[15:0], 8'hFF};
            end
            GRP_FUEL:
            begin
                ps = 8'hF2;
                d = {16'hFFFF, fu_s[31:16], 16'hFFFF, fu_s[15:0]};
            end
            default:
            begin
                ps = 8'hF6;
                d = {40'hFF_FFFF_FFFF, in_s[15:0], 8'hFF};
            end
        endcase
        exp_frame = {3'h6, 2'h0, 8'hFE, ps, 8'h00, 4'h8, d};
    endfunction : exp_frame

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (got)
        begin
            if (nacc < 13)
            begin
                g = exp_seq[nacc];
                ef = exp_frame(g);
                t[nacc] = cyc;
                `CHK("id", ef.id, got_frame.id)
                `CHK("dlc", 4'h8, got_frame.dlc)
                if (g == GRP_CRUISE)
                    `CHK("cruise", ef, got_frame)
                else if (g == GRP_FUEL)
                    `CHK("fuel", ef, got_frame)
                else
                    `CHK("inlet", ef, got_frame)
            end
            else
                `CHK("extra frame", 1'b0, 1'b1)
            nacc = nacc + 1;
        end
    end

    initial
    begin
        repeat (12000) @(posedge pclk);
        err_total++;
        conclude();
    end

    initial
    begin
        exp_seq = '{GRP_CRUISE, GRP_FUEL, GRP_CRUISE, GRP_FUEL, GRP_CRUISE,
                    GRP_FUEL, GRP_CRUISE, GRP_FUEL, GRP_CRUISE, GRP_FUEL,
                    GRP_INLET, GRP_CRUISE, GRP_FUEL};
        {presetn, psel, penable, pwrite, stall} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        {cyc, nacc, err_total, cmp_count} = '0;
        sp_s = 32'h0077_1234;
        sw_s = 32'h0055_E41B;
        fu_s = 32'h5678_9ABC;
        in_s = 32'h0000_4321;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, ADDR_SPEED, 32'hA577_1234);
        apb(1'b0, ADDR_SPEED, 32'h0);
        `CHK("speed reg", sp_s, q)
        apb(1'b1, ADDR_SWITCH, sw_s);
        apb(1'b1, ADDR_FUEL, fu_s);
        apb(1'b1, ADDR_INLET, in_s);
        apb(1'b1, ADDR_CTRL, 32'h1);
        // Stall across the third tick: the frame must wait, not vanish.
        wait (nacc == 4);
        @(posedge pclk);
        stall <= 1'b1;
        repeat (1100) @(posedge pclk);
        `CHK("held valid", 1'b1, tx_valid)
        stall <= 1'b0;
        wait (nacc == 6);
        @(posedge pclk);
        apb(1'b1, ADDR_SPEED, 32'h0088_2345);
        sp_s = 32'h0088_2345;
        wait (nacc == 13);
        @(posedge pclk);
        `CHK("cruise period", 1000, t[2] - t[0])
        `CHK("fuel period", 1000, t[3] - t[1])
        `CHK("fuel after", 2, t[1] - t[0])
        `CHK("inlet time", 4004, t[10] - t[0])
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("status", 32'h0000_0D00, q)
        apb(1'b0, 8'h18, 32'h0);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, q)
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (1200) @(posedge pclk);
        `CHK("frames when off", 13, nacc)
        conclude();
    end
endmodule : tb_status_framer
